//--- dpb_pkg.sv
package dpb_pkg;

	// ********************************
	// timing
	// ********************************
	localparam int CLK_HZ = 10_000_000;
	localparam int BRAKE_ON_LIMIT_MS = 15000;
	localparam int BRAKE_ON_LIMIT_CYCLES = BRAKE_ON_LIMIT_MS * (CLK_HZ / 1000);
	localparam int BRAKE_PWM_CYCLES = 1000;

	// ********************************
	// arithmetic constants
	// ********************************
	localparam logic [6:0] SPEED_FACTOR = 7'h78;
	localparam logic [6:0] GAIN_SCALE = 7'h64;
	localparam logic [15:0] DUTY_MAX = 16'h001e;
	localparam logic [6:0] DUTY_SCALE = 7'h64;
	localparam logic [4:0] DIV_STEPS = 5'h17;

	// ********************************
	// parameter bank map, 32 codes per group
	// ********************************
	localparam int BANK_DEPTH = 128;
	localparam logic [1:0] GRP_DRV = 2'h0;
	localparam logic [1:0] GRP_FU1 = 2'h1;
	localparam logic [1:0] GRP_FU2 = 2'h2;
	localparam logic [1:0] GRP_IO = 2'h3;
	localparam logic [4:0] EXIT_CODE_IDX = 5'h1f;

	localparam logic [6:0] IDX_ACC = 7'h01;
	localparam logic [6:0] IDX_DEC = 7'h02;
	localparam logic [6:0] IDX_BASE = 7'h21;
	localparam logic [6:0] IDX_FWD_BOOST = 7'h22;
	localparam logic [6:0] IDX_REV_BOOST = 7'h23;
	localparam logic [6:0] IDX_VF_PATTERN = 7'h24;
	localparam logic [6:0] IDX_THERM_1MIN = 7'h25;
	localparam logic [6:0] IDX_THERM_CONT = 7'h26;
	localparam logic [6:0] IDX_STALL = 7'h27;
	localparam logic [6:0] IDX_POLES = 7'h28;
	localparam logic [6:0] IDX_USER_VF_FIRST = 7'h29;
	localparam logic [6:0] IDX_USER_VF_LAST = 7'h30;
	localparam logic [6:0] IDX_RATED_CURR = 7'h41;
	localparam logic [6:0] IDX_SPEED_GAIN = 7'h42;
	localparam logic [6:0] IDX_BRAKE_MODE = 7'h43;
	localparam logic [6:0] IDX_BRAKE_DUTY = 7'h44;
	localparam logic [6:0] IDX_ALT_FIRST = 7'h45;
	localparam logic [6:0] IDX_ALT_LAST = 7'h4e;
	localparam logic [6:0] IDX_INIT_SEL = 7'h4f;
	localparam logic [6:0] IDX_WRITE_LOCK = 7'h50;
	localparam logic [6:0] IDX_SPEED_MODE = 7'h51;
	localparam logic [6:0] IDX_TERM_DEF0 = 7'h61;

	// ********************************
	// codes and reset values
	// ********************************
	localparam int SWITCHED_COUNT = 10;
	localparam int TERM_COUNT = 3;
	localparam logic [15:0] TERM_ALT_FUNC = 16'h0007;
	localparam logic [15:0] LOCK_CODE = 16'h000c;
	localparam logic [15:0] BRAKE_MODE_EXT = 16'h0001;
	localparam logic [15:0] INIT_ALL = 16'h0001;
	localparam logic [15:0] INIT_LAST = 16'h0005;
	localparam logic [7:0] CHAR_UNLOCKED = 8'h55;
	localparam logic [7:0] CHAR_LOCKED = 8'h4c;
	localparam logic [15:0] RST_POLES = 16'h0004;
	localparam logic [15:0] RST_SPEED_GAIN = 16'h0064;
	localparam logic [15:0] RST_ZERO = 16'h0000;

endpackage

//--- dpb_if.sv
`timescale 1ns/1ps
interface dpb_speed_if;
	logic [15:0] freq;
	logic [15:0] poles;
	logic [15:0] gain;
	logic mech_sel;
	logic [31:0] speed;
	modport calc(input freq, input poles, input gain, input mech_sel,
		output speed);
	modport ctrl(output freq, output poles, output gain, output mech_sel,
		input speed);
endinterface

interface dpb_brake_if;
	logic [15:0] mode;
	logic [15:0] duty;
	logic demand;
	logic on;
	logic expired;
	modport drv(input mode, input duty, input demand, output on,
		output expired);
	modport ctrl(output mode, output duty, output demand, input on,
		input expired);
endinterface

//--- dpb_speed_calc.sv
`timescale 1ns/1ps
module dpb_speed_calc import dpb_pkg::*; (
	// clock
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// operands and result
	dpb_speed_if.calc sp
);

	typedef enum logic [1:0] {SC_IDLE, SC_DIV, SC_SCALE} dpb_sc_state_t;

	typedef struct packed {
		dpb_sc_state_t st;
		logic [22:0] num;
		logic [15:0] den;
		logic [22:0] quot;
		logic [16:0] rem;
		logic [4:0] cnt;
		logic [31:0] speed;
	} dpb_sc_t;

	dpb_sc_t s;
	dpb_sc_t next_s;
	logic [16:0] trial;
	logic [38:0] scaled;

	// restoring divide, one quotient bit per cycle; a fresh figure
	// every ~25 cycles is plenty for a display
	always_comb begin
		next_s = s;
		trial = {s.rem[15:0], s.num[22]};
		scaled = 39'({16'h0000, s.quot} * {23'h000000, sp.gain})
			/ 39'(GAIN_SCALE);
		unique case (s.st)
			SC_IDLE: begin
				next_s.num = 23'(sp.freq) * 23'(SPEED_FACTOR); // see RULE1
				next_s.den = sp.poles;
				next_s.quot = 23'h000000;
				next_s.rem = 17'h00000;
				next_s.cnt = DIV_STEPS;
				next_s.st = SC_DIV;
			end
			SC_DIV: begin
				next_s.num = {s.num[21:0], 1'b0};
				if (trial >= {1'b0, s.den}) begin
					next_s.rem = trial - {1'b0, s.den};
					next_s.quot = {s.quot[21:0], 1'b1};
				end else begin
					next_s.rem = trial;
					next_s.quot = {s.quot[21:0], 1'b0};
				end
				next_s.cnt = s.cnt - 5'h01;
				if (s.cnt == 5'h01)
					next_s.st = SC_SCALE;
			end
			SC_SCALE: begin
				// zero poles would be a meaningless divide
				if (s.den == 16'h0000)
					next_s.speed = 32'h00000000;
				else if (sp.mech_sel)
					next_s.speed = scaled[31:0]; // see RULE2
				else
					next_s.speed = {9'h000, s.quot}; // see RULE1
				next_s.st = SC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			s <= '{SC_IDLE, 23'h000000, 16'h0000, 23'h000000, 17'h00000,
				5'h00, 32'h00000000};
		else if (ce_i)
			s <= next_s;
	end

	assign sp.speed = s.speed;

endmodule

//--- dpb_brake_ctrl.sv
`timescale 1ns/1ps
module dpb_brake_ctrl import dpb_pkg::*; #(
	parameter int LIMIT_CYCLES = BRAKE_ON_LIMIT_CYCLES,
	parameter int PWM_PERIOD = BRAKE_PWM_CYCLES
) (
	// clock
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// brake settings and switch
	dpb_brake_if.drv br
);

	typedef struct packed {
		logic [15:0] pwm_cnt;
		logic [31:0] on_cnt;
		logic expired;
		logic on;
	} dpb_br_t;

	dpb_br_t s;
	dpb_br_t next_s;
	logic [15:0] duty_c;
	logic [31:0] thr;
	logic enabled;

	always_comb begin
		next_s = s;
		// out-of-range duty is held at the ceiling
		duty_c = (br.duty > DUTY_MAX) ? DUTY_MAX : br.duty; // see RULE4
		thr = 32'(duty_c) * 32'(PWM_PERIOD) / 32'(DUTY_SCALE);
		enabled = (br.mode == BRAKE_MODE_EXT) && br.demand; // see RULE3
		if (s.pwm_cnt == 16'(PWM_PERIOD - 1))
			next_s.pwm_cnt = 16'h0000;
		else
			next_s.pwm_cnt = s.pwm_cnt + 16'h0001;
		if (!enabled) begin
			next_s.on_cnt = 32'h00000000;
			next_s.expired = 1'b0;
		end else if (s.on_cnt >= 32'(LIMIT_CYCLES - 1)) begin
			next_s.expired = 1'b1; // see RULE4
		end else begin
			next_s.on_cnt = s.on_cnt + 32'h00000001;
		end
		// switch drops at expiry though demand persists
		next_s.on = enabled && !next_s.expired
			&& ({16'h0000, s.pwm_cnt} < thr); // see RULE5
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			s <= '{16'h0000, 32'h00000000, 1'b0, 1'b0};
		else if (ce_i)
			s <= next_s;
	end

	assign br.on = s.on;
	assign br.expired = s.expired;

endmodule

//--- dpb_param_bank.sv
// Operation
// RULE1: speed shown is 120 times output frequency over pole count.
// RULE2: mechanical display mode multiplies that speed by the display gain.
// RULE3: brake mode 0 never turns the brake switch on.
// RULE4: external mode takes duty 0 to 30 percent, on time at most 15 s.
// RULE5: switch goes off at on-time expiry even while braking is demanded.
// RULE6: operator programs duty from decel, accel, steady and stop times.
// RULE7: second-motor set visible only if a terminal is second-function.
// RULE8: second set used only while such a terminal is active.
// RULE9: ten parameters switch between first and second motor sets.
// RULE10: all other parameters are identical for both motors.
// RULE11: user volts-per-hertz table is one table shared by both motors.
// RULE12: operator swaps motor wiring only with the motor stopped.
// RULE13: keypad uploads whole bank and downloads it to another drive; hidden second-motor codes read 0 and ignore writes.
// RULE14: initialise selector 1..5 restores defaults by group, reads 0.
// RULE15: writing 12 to the lock parameter toggles write protection.
// RULE16: keypad shows U unlocked and L locked.
// RULE17: function key on the return code leaves the current group.
// RULE18: locked bank ignores writes except to the lock parameter.
`timescale 1ns/1ps
module dpb_param_bank import dpb_pkg::*; #(
	parameter int BRAKE_LIMIT = BRAKE_ON_LIMIT_CYCLES,
	parameter int PWM_PERIOD = BRAKE_PWM_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// register port
	input wire logic [6:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// drive core
	input wire logic [15:0] out_freq_i,
	input wire logic brake_demand_i,
	output logic [SWITCHED_COUNT-1:0][15:0] motor_param_o,
	output logic alt_motor_active_o,
	output logic [31:0] speed_disp_o,
	output logic brake_on_o,
	output logic brake_expired_o,
	// terminals and keypad pins
	input wire logic [TERM_COUNT-1:0] term_i,
	input wire logic func_key_i,
	output logic alt_set_visible_o,
	output logic lock_o,
	output logic [7:0] lock_char_o,
	output logic group_exit_o
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic [BANK_DEPTH-1:0][15:0] bank;
		logic [15:0] rdata;
		logic locked;
		logic [6:0] cursor;
		logic [TERM_COUNT-1:0] term_meta;
		logic [TERM_COUNT-1:0] term_sync;
		logic key_meta;
		logic key_sync;
		logic key_prev;
		logic group_exit;
		logic [SWITCHED_COUNT-1:0][15:0] motor_param;
		logic alt_active;
		logic visible;
		logic [7:0] lock_char;
	} dpb_top_t;

	dpb_top_t s;
	dpb_top_t next_s;
	logic [TERM_COUNT-1:0] alt_defined;
	logic any_alt;
	logic is_alt_idx;
	logic [15:0] rd_val;
	logic wr_ok;

	dpb_speed_if spd ();
	dpb_brake_if brk ();

	// ********************************
	// functions
	// ********************************
	function automatic logic [15:0] default_of(input logic [6:0] idx);
		if (idx == IDX_POLES)
			return RST_POLES;
		else if (idx == IDX_SPEED_GAIN)
			return RST_SPEED_GAIN;
		else
			return RST_ZERO;
	endfunction

	// first-motor home of each switched parameter, in alternate order
	function automatic logic [6:0] first_index(input int i);
		unique case (i)
			0: return IDX_ACC;
			1: return IDX_DEC;
			2: return IDX_BASE;
			3: return IDX_VF_PATTERN;
			4: return IDX_FWD_BOOST;
			5: return IDX_REV_BOOST;
			6: return IDX_STALL;
			7: return IDX_THERM_1MIN;
			8: return IDX_THERM_CONT;
			default: return IDX_RATED_CURR;
		endcase
	endfunction

	function automatic logic init_hits(input logic [15:0] sel,
		input logic [6:0] idx);
		if (sel == INIT_ALL)
			return 1'b1;
		return idx[6:5] == 2'(sel - 16'h0002); // see RULE14
	endfunction

	function automatic dpb_top_t reset_state();
		dpb_top_t r;
		r = '0;
		for (int j = 0; j < BANK_DEPTH; j++)
			r.bank[j] = default_of(7'(j));
		for (int i = 0; i < SWITCHED_COUNT; i++)
			r.motor_param[i] = default_of(first_index(i));
		r.lock_char = CHAR_UNLOCKED;
		return r;
	endfunction

	// ********************************
	// next state
	// ********************************
	always_comb begin
		next_s = s;
		next_s.term_meta = term_i;
		next_s.term_sync = s.term_meta;
		next_s.key_meta = func_key_i;
		next_s.key_sync = s.key_meta;
		next_s.key_prev = s.key_sync;
		next_s.group_exit = 1'b0;
		next_s.rdata = 16'h0000;

		for (int t = 0; t < TERM_COUNT; t++)
			alt_defined[t] = s.bank[IDX_TERM_DEF0 + 7'(t)] == TERM_ALT_FUNC;
		any_alt = |alt_defined; // see RULE7
		is_alt_idx = (addr_i >= IDX_ALT_FIRST) && (addr_i <= IDX_ALT_LAST);

		// read back; keypad upload reaches the bank, the second-motor set only while it is visible
		if (addr_i == IDX_INIT_SEL)
			rd_val = 16'h0000; // see RULE14
		else if (addr_i == IDX_WRITE_LOCK)
			rd_val = {15'h0000, s.locked};
		else if (is_alt_idx && !any_alt)
			rd_val = 16'h0000; // see RULE7
		else
			rd_val = s.bank[addr_i]; // see RULE13
		if (rd_i)
			next_s.rdata = rd_val;
		if (rd_i || wr_i)
			next_s.cursor = addr_i;

		// writes; download from keypad lands here too
		wr_ok = wr_i && !s.locked && !(is_alt_idx && !any_alt); // see RULE18
		if (wr_i && addr_i == IDX_WRITE_LOCK) begin
			if (wdata_i == LOCK_CODE)
				next_s.locked = !s.locked; // see RULE15
		end else if (wr_ok && addr_i == IDX_INIT_SEL) begin
			if (wdata_i >= INIT_ALL && wdata_i <= INIT_LAST) begin
				for (int j = 0; j < BANK_DEPTH; j++)
					if (init_hits(wdata_i, 7'(j)))
						next_s.bank[j] = default_of(7'(j)); // see RULE14
			end
		end else if (wr_ok) begin
			next_s.bank[addr_i] = wdata_i; // see RULE13
		end
		next_s.lock_char = next_s.locked ? CHAR_LOCKED
			: CHAR_UNLOCKED; // see RULE16

		// group leave on rising key edge at the return code
		if (s.key_sync && !s.key_prev && s.cursor[4:0] == EXIT_CODE_IDX)
			next_s.group_exit = 1'b1; // see RULE17

		// motor set select; the user v/f points and every other code
		// live once in the bank and bypass this mux: see RULE11
		next_s.visible = any_alt;
		next_s.alt_active = |(s.term_sync & alt_defined); // see RULE8
		for (int i = 0; i < SWITCHED_COUNT; i++) begin
			if (next_s.alt_active)
				next_s.motor_param[i] =
					s.bank[IDX_ALT_FIRST + 7'(i)]; // see RULE9
			else
				next_s.motor_param[i] = s.bank[first_index(i)]; // see RULE8
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			s <= reset_state();
		else if (ce_i)
			s <= next_s;
	end

	// ********************************
	// submodules
	// ********************************
	// pole count and gain are shared codes, not switched: see RULE10
	assign spd.freq = out_freq_i;
	assign spd.poles = s.bank[IDX_POLES];
	assign spd.gain = s.bank[IDX_SPEED_GAIN];
	assign spd.mech_sel = s.bank[IDX_SPEED_MODE] != 16'h0000; // see RULE2

	assign brk.mode = s.bank[IDX_BRAKE_MODE];
	assign brk.duty = s.bank[IDX_BRAKE_DUTY];
	assign brk.demand = brake_demand_i;

	dpb_speed_calc u_speed (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.sp(spd)
	);

	dpb_brake_ctrl #(
		.LIMIT_CYCLES(BRAKE_LIMIT),
		.PWM_PERIOD(PWM_PERIOD)
	) u_brake (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.br(brk)
	);

	// ********************************
	// outputs
	// ********************************
	assign rdata_o = s.rdata;
	assign motor_param_o = s.motor_param;
	assign alt_motor_active_o = s.alt_active;
	assign speed_disp_o = spd.speed;
	assign brake_on_o = brk.on;
	assign brake_expired_o = brk.expired;
	assign alt_set_visible_o = s.visible;
	assign lock_o = s.locked;
	assign lock_char_o = s.lock_char;
	assign group_exit_o = s.group_exit;

endmodule

//--- dpb_chk_sva.sv
`timescale 1ns/1ps
module dpb_chk #(
	parameter int PWM_PERIOD = 1000
) (
	// clock
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// register port
	input wire logic [6:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// brake, motor select, keypad
	input wire logic brake_on_o,
	input wire logic brake_expired_o,
	input wire logic alt_motor_active_o,
	input wire logic alt_set_visible_o,
	input wire logic lock_o,
	input wire logic [7:0] lock_char_o,
	input wire logic group_exit_o
);
	// ********************************
	// on-run counter
	// ********************************
	localparam int ON_MAX = PWM_PERIOD * 30 / 100;
	int on_run;
	always_ff @(posedge clk_i) begin
		if (reset_i || !brake_on_o) begin
			on_run <= 0;
		end else if (ce_i) begin
			// a frozen switch is not a longer pulse
			on_run <= on_run + 1;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ********************************
	// assertions
	// ********************************
	a_lock_toggle: assert property (
		ce_i && wr_i && addr_i == 7'h50 && wdata_i == 16'h000c
		|=> lock_o != $past(lock_o)) else $error("lock did not toggle");
	a_char_locked: assert property (
		lock_o |-> lock_char_o == 8'h4c) else $error("locked char");
	a_char_unlocked: assert property (
		!lock_o |-> lock_char_o == 8'h55) else $error("unlocked char");
	a_init_reads_zero: assert property (
		ce_i && rd_i && addr_i == 7'h4f |=> rdata_o == 16'h0000)
		else $error("init selector not zero");
	a_rdata_idle: assert property (
		ce_i && !rd_i |=> rdata_o == 16'h0000) else $error("rdata held");
	a_exit_one_cycle: assert property (
		group_exit_o |=> !group_exit_o) else $error("exit pulse long");
	a_alt_needs_def: assert property (
		!alt_set_visible_o [*3] |-> !alt_motor_active_o)
		else $error("alt set without define");
	a_duty_bound: assert property (
		on_run <= ON_MAX) else $error("brake on too long");
	a_expired_off: assert property (
		brake_expired_o |-> !brake_on_o) else $error("brake on after expiry");
	c_lock: cover property ($rose(lock_o));
	c_brake: cover property ($rose(brake_on_o));
	c_exit: cover property (group_exit_o);
	c_alt: cover property (alt_motor_active_o);
endmodule

bind dpb_param_bank dpb_chk #(.PWM_PERIOD(PWM_PERIOD)) i_chk (
	.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.brake_on_o(brake_on_o), .brake_expired_o(brake_expired_o),
	.alt_motor_active_o(alt_motor_active_o),
	.alt_set_visible_o(alt_set_visible_o), .lock_o(lock_o),
	.lock_char_o(lock_char_o), .group_exit_o(group_exit_o));

//--- dpb_keypad_model.sv
`timescale 1ns/1ps
module dpb_keypad_model (
	// clock
	input wire logic clk_i,
	// terminals and key
	output logic [2:0] term_o,
	output logic key_o
);
	initial begin
		term_o = 3'h0;
		key_o = 1'b0;
	end
	// only called with brake demand low, while out_freq_i is still 16'h0032
	task automatic set_term(input logic [2:0] v);
		@(posedge clk_i);
		term_o <= v;
	endtask
	// held well past the two-flop sync so the edge is seen
	task automatic press();
		@(posedge clk_i);
		key_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		key_o <= 1'b0;
	endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench import dpb_pkg::*; ;
	logic clk_i, reset_i, ce_i, wr_i, rd_i, brake_demand_i;
	logic [6:0] addr_i;
	logic [15:0] wdata_i, rdata_o, out_freq_i;
	logic [SWITCHED_COUNT-1:0][15:0] mp;
	logic alt, brake_on, expired, vis, lock, key, gexit;
	logic [31:0] spd, c;
	logic [7:0] lchar;
	logic [2:0] term;
	int errors = 0;
	int checked = 0;
	dpb_param_bank #(.BRAKE_LIMIT(200), .PWM_PERIOD(20)) i_dut (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.out_freq_i(out_freq_i), .brake_demand_i(brake_demand_i),
		.motor_param_o(mp), .alt_motor_active_o(alt), .speed_disp_o(spd),
		.brake_on_o(brake_on), .brake_expired_o(expired), .term_i(term),
		.func_key_i(key), .alt_set_visible_o(vis), .lock_o(lock),
		.lock_char_o(lchar), .group_exit_o(gexit));
	dpb_keypad_model i_pad (.clk_i(clk_i), .term_o(term), .key_o(key));
	// ********************************
	// tasks
	// ********************************
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk($sformatf("rd %h", a), {16'h0, e}, {16'h0, rdata_o});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic count_on(input int n);
		c = 32'h0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			c = c + {31'h0, brake_on};
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		wrap_up();
	end
	// ********************************
	// sequence
	// ********************************
	initial begin
		reset_i = 1'b1;
		ce_i = 1'b1;
		{wr_i, rd_i, brake_demand_i} = 3'h0;
		addr_i = 7'h00;
		wdata_i = 16'h0000;
		out_freq_i = 16'h0032;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(IDX_POLES, RST_POLES);
		rd(IDX_SPEED_GAIN, RST_SPEED_GAIN);
		tick(60);
		chk("speed", 32'h78 * 32'h32 / 32'h4, spd);
		wr(IDX_POLES, 16'h0006);
		tick(60);
		chk("speed", 32'h78 * 32'h32 / 32'h6, spd);
		wr(IDX_SPEED_GAIN, 16'h0096);
		wr(IDX_SPEED_MODE, 16'h0001);
		tick(60);
		chk("mech", 32'h3e8 * 32'h96 / 32'h64, spd);
		wr(IDX_WRITE_LOCK, LOCK_CODE);
		tick(1);
		chk("lock", 32'h1, {31'h0, lock});
		chk("char", 32'h4c, {24'h0, lchar});
		wr(IDX_ACC, 16'h0005);
		rd(IDX_ACC, 16'h0000);
		rd(IDX_WRITE_LOCK, 16'h0001);
		wr(IDX_WRITE_LOCK, LOCK_CODE);
		tick(1);
		chk("char", 32'h55, {24'h0, lchar});
		wr(IDX_ALT_FIRST, 16'h0016);
		rd(IDX_ALT_FIRST, 16'h0000);
		chk("vis", 32'h0, {31'h0, vis});
		wr(IDX_TERM_DEF0, TERM_ALT_FUNC);
		wr(IDX_ACC, 16'h000b);
		wr(IDX_ALT_FIRST, 16'h0016);
		wr(IDX_THERM_1MIN, 16'h0021);
		wr(IDX_ALT_FIRST + 7'h7, 16'h002c);
		rd(IDX_THERM_1MIN, 16'h0021);
		tick(4);
		chk("vis", 32'h1, {31'h0, vis});
		chk("acc1", 32'hb, {16'h0, mp[0]});
		i_pad.set_term(3'h1);
		tick(5);
		chk("alt", 32'h1, {31'h0, alt});
		chk("acc2", 32'h16, {16'h0, mp[0]});
		chk("th2", 32'h2c, {16'h0, mp[7]});
		chk("speed2", 32'h5dc, spd);
		i_pad.set_term(3'h2);
		tick(5);
		chk("alt", 32'h0, {31'h0, alt});
		chk("th1", 32'h21, {16'h0, mp[7]});
		rd(7'h1f, 16'h0000);
		c = 32'h0;
		fork
			i_pad.press();
			repeat (20) begin
				@(posedge clk_i);
				#1;
				c = c + {31'h0, gexit};
			end
		join
		chk("exit", 32'h1, c);
		// one marker per group, then clear the groups one by one
		for (int g = 0; g < 4; g++) wr({g[1:0], 5'h03}, 16'h0005);
		for (int v = 2; v < 6; v++) begin
			wr(IDX_INIT_SEL, v[15:0]);
			rd({v[1:0] - 2'h2, 5'h03}, 16'h0000);
			if (v < 5) rd({v[1:0] - 2'h1, 5'h03}, 16'h0005);
		end
		wr(IDX_POLES, 16'h0009);
		wr(IDX_INIT_SEL, INIT_ALL);
		rd(IDX_POLES, RST_POLES);
		rd(IDX_INIT_SEL, 16'h0000);
		@(posedge clk_i);
		brake_demand_i <= 1'b1;
		count_on(100);
		chk("db none", 32'h0, c);
		@(posedge clk_i);
		brake_demand_i <= 1'b0;
		wr(IDX_BRAKE_MODE, BRAKE_MODE_EXT);
		wr(IDX_BRAKE_DUTY, 16'h0032);
		brake_demand_i <= 1'b1;
		tick(5);
		count_on(40);
		chk("db duty", 32'h28 * 32'h1e / 32'h64, c);
		tick(200);
		chk("expired", 32'h1, {31'h0, expired});
		chk("db on", 32'h0, {31'h0, brake_on});
		@(posedge clk_i);
		brake_demand_i <= 1'b0;
		tick(3);
		chk("expired", 32'h0, {31'h0, expired});
		wrap_up();
	end
endmodule
